// ---- src/sdc_pkg.sv ----
// Behaviour
// - Power-down turns analog and filter sections off; common-mode and reference enables still apply
// - Sleep keeps bandgap, amplifier, filter, common-mode and reference enables; others off
// - All mode bits low after a reset pulse: normal conversions run
// - Reset bit holds filter in reset, analog powered
// - Host pulses reset low-high-low; conversions start after
// - Each finished conversion sets the completion flag
// - Host alone clears the completion flag by writing
// - Hold off: every conversion overwrites the result
// - Hold on: keep latest result, discard later ones
// - Hold stops neither converter nor completion flag
// - Reference select picks internal or external pair
// - Result is 24-bit two's complement
// - Result top bit is the sign
// - Over-range input forces result to minimum code
// - Result bytes read at 04h, 05h, 06h
// - Host configures in order, releases modes, pulses reset
// - Host reads result bytes only after flag high
// - Host programs divider for the converter clock
// - Divider: 2*(code+1), all-ones passes undivided
// - Channel selects power the temperature sensor
// - Each reference buffer has its own enable
// - Common-mode generator has its own enable
package sdc_pkg;
  localparam int RES_W = 24;
  // Link register offsets
  localparam logic [7:0] A_CR0    = 8'h01;
  localparam logic [7:0] A_CR1    = 8'h02;
  localparam logic [7:0] A_CHSEL  = 8'h03;
  localparam logic [7:0] A_RES_L  = 8'h04;
  localparam logic [7:0] A_RES_M  = 8'h05;
  localparam logic [7:0] A_RES_H  = 8'h06;
  localparam logic [7:0] A_CLKDIV = 8'h09;
  // Control zero bit positions
  localparam int CR0_PD  = 7;
  localparam int CR0_SLP = 6;
  localparam int CR0_RST = 5;
  localparam int CR0_REF = 4;
  localparam int CR0_VCM = 3;
  // Control one bit positions
  localparam int CR1_HOLD = 7;
  localparam int CR1_VRN  = 6;
  localparam int CR1_VRP  = 5;
  localparam int CR1_FLM  = 3;
  localparam int CR1_EOC  = 1;
  localparam logic [7:0] CR0_RESET = 8'h80;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [2:0] TEMP_SEL  = 3'h7;
  localparam logic [4:0] DIV_BYPASS = 5'h1F;
  // Conversion length: base times (16 << rate code) converter ticks
  localparam logic [15:0] BASE_LONG  = 16'h001E;
  localparam logic [15:0] BASE_SHORT = 16'h000C;
  localparam logic [3:0]  OSR_SHIFT  = 4'h4;
  localparam logic [23:0] RES_OVER   = 24'h800000;
  // Power enable vector positions
  localparam int PW_BG   = 0;
  localparam int PW_AMP  = 1;
  localparam int PW_MOD  = 2;
  localparam int PW_TEMP = 3;
  localparam int PW_VRN  = 4;
  localparam int PW_VRP  = 5;
  localparam int PW_FILT = 6;
  localparam int PW_FRST = 7;
  localparam int PW_VCM  = 8;
  localparam int PW_REFX = 9;
  localparam int PWR_W   = 10;
  // Host clock and target converter clock
  localparam longint CLK_HZ      = 40000000;
  localparam longint CONV_CLK_HZ = 4915200;
  localparam logic [4:0] CLKDIV_CODE = 5'(CLK_HZ / (2 * CONV_CLK_HZ) - 1);
  // Host bus register offsets
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_CFG    = 4'h4;
  localparam logic [3:0] H_STATUS = 4'h8;
  localparam logic [3:0] H_RESULT = 4'hC;
  localparam logic [23:0] HCFG_RESET = 24'h000000;
  localparam logic [3:0] ST_START_END = 4'h5;
  localparam logic [3:0] ST_POLL      = 4'h8;
  localparam logic [3:0] ST_READ_END  = 4'hC;
  typedef enum logic [1:0] {
    MD_PD = 2'b00, MD_SLEEP = 2'b01, MD_NORMAL = 2'b11, MD_RESET = 2'b10
  } sdc_mode_type;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_ISSUE = 2'b01, HS_WAIT = 2'b11
  } sdc_hstate_type;
endpackage : sdc_pkg

// ---- src/sdc_link_if.sv ----
`timescale 1ns/1ps
interface sdc_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       ack;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata, output ack);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input ack);
endinterface : sdc_link_if

// ---- src/sdc_device.sv ----
`timescale 1ns/1ps
module sdc_device (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  sdc_link_if.dev                         link,
  input  wire logic [sdc_pkg::RES_W-1:0]  sample_data,
  input  wire logic                       sample_over,
  output logic      [sdc_pkg::PWR_W-1:0]  power_en,
  output logic                            conv_tick
);
  import sdc_pkg::*;

  logic [7:0]       cr0_q;
  logic [7:0]       cr0_d;
  logic [7:0]       cr1_q;
  logic [7:0]       cr1_d;
  logic [5:0]       chsel_q;
  logic [5:0]       chsel_d;
  logic [4:0]       ckdiv_q;
  logic [4:0]       ckdiv_d;
  logic             eoc_q;
  logic             eoc_d;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] result_d;
  logic             armed_q;
  logic             armed_d;
  logic [5:0]       div_q;
  logic [5:0]       div_d;
  logic [15:0]      cnt_q;
  logic [15:0]      cnt_d;
  logic             ack_q;
  logic             ack_d;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;
  logic [PWR_W-1:0] pwr_q;
  logic [PWR_W-1:0] pwr_d;
  logic             done_q;
  logic             done_d;

  sdc_mode_type     mode;
  logic             tick;
  logic [15:0]      conv_last;
  logic [15:0]      base;
  logic             conv_done;
  logic             temp_sel;
  logic [5:0]       div_last;

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;
  assign power_en   = pwr_q;
  assign conv_tick  = done_q;

  always_comb begin
    cr0_d    = cr0_q;
    cr1_d    = cr1_q;
    chsel_d  = chsel_q;
    ckdiv_d  = ckdiv_q;
    eoc_d    = eoc_q;
    result_d = result_q;
    armed_d  = armed_q;
    rdata_d  = rdata_q;
    ack_d    = link.wr | link.rd;
    pwr_d    = '0;

    // Power-down outranks sleep, sleep outranks reset
    if (cr0_q[CR0_PD]) begin
      mode = MD_PD;
    end else if (cr0_q[CR0_SLP]) begin
      mode = MD_SLEEP;
    end else if (cr0_q[CR0_RST]) begin
      mode = MD_RESET;
    end else begin
      mode = MD_NORMAL;
    end

    div_last = {ckdiv_q, 1'b1};
    tick     = (ckdiv_q == DIV_BYPASS) || (div_q == div_last);
    div_d    = tick ? 6'h00 : 6'(div_q + 6'h01);

    // Decimation length follows rate and filter mode fields
    base      = cr1_q[CR1_FLM] ? BASE_SHORT : BASE_LONG;
    conv_last = 16'((base << (OSR_SHIFT + {1'b0, cr0_q[2:0]})) - 16'h0001);

    // armed by the reset pulse, lost on power-down
    unique case (mode)
      MD_PD:     armed_d = 1'b0;
      MD_RESET:  armed_d = 1'b1;
      default:   armed_d = armed_q;
    endcase

    // counting only in normal mode after arming
    conv_done = 1'b0;
    cnt_d     = cnt_q;
    if (mode != MD_NORMAL) begin
      cnt_d = 16'h0000;
    end else if (armed_q && tick) begin
      conv_done = (cnt_q >= conv_last);
      cnt_d     = conv_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
    end
    done_d = conv_done;

    if (conv_done && !cr1_q[CR1_HOLD]) begin
      result_d = sample_over ? RES_OVER : sample_data;
    end

    if (link.wr) begin
      unique case (link.addr)
        A_CR0: cr0_d = link.wdata;
        A_CR1: begin
          cr1_d = {link.wdata[7:2], 2'b00};
          if (!link.wdata[CR1_EOC]) begin
            eoc_d = 1'b0;
          end
        end
        A_CHSEL:  chsel_d = link.wdata[5:0];
        A_CLKDIV: ckdiv_d = link.wdata[4:0];
        default: ;
      endcase
    end

    // completion sets the flag, beating a clear
    if (conv_done) begin
      eoc_d = 1'b1;
    end

    if (link.rd) begin
      unique case (link.addr)
        A_CR0:    rdata_d = cr0_q;
        A_CR1:    rdata_d = {cr1_q[7:2], eoc_q, 1'b0};
        A_CHSEL:  rdata_d = {2'b00, chsel_q};
        A_RES_L:  rdata_d = result_q[7:0];
        A_RES_M:  rdata_d = result_q[15:8];
        A_RES_H:  rdata_d = result_q[23:16];
        A_CLKDIV: rdata_d = {3'b000, ckdiv_q};
        default:  rdata_d = 8'h00;
      endcase
    end

    // sensor powered when either side selects it
    temp_sel = (chsel_q[2:0] == TEMP_SEL) || (chsel_q[5:3] == TEMP_SEL);

    pwr_d[PW_VCM]  = cr0_q[CR0_VCM];
    pwr_d[PW_REFX] = cr0_q[CR0_REF];
    unique case (mode)
      MD_PD: ;
      MD_SLEEP: begin
        pwr_d[PW_BG]   = 1'b1;
        pwr_d[PW_AMP]  = 1'b1;
        pwr_d[PW_FILT] = 1'b1;
      end
      default: begin
        pwr_d[PW_BG]   = 1'b1;
        pwr_d[PW_AMP]  = 1'b1;
        pwr_d[PW_MOD]  = 1'b1;
        pwr_d[PW_TEMP] = temp_sel;
        pwr_d[PW_VRN]  = cr1_q[CR1_VRN];
        pwr_d[PW_VRP]  = cr1_q[CR1_VRP];
        pwr_d[PW_FILT] = 1'b1;
        pwr_d[PW_FRST] = (mode == MD_RESET);
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr0_q    <= CR0_RESET;
      cr1_q    <= CR1_RESET;
      chsel_q  <= 6'h00;
      ckdiv_q  <= 5'h00;
      eoc_q    <= 1'b0;
      result_q <= 24'h000000;
      armed_q  <= 1'b0;
      div_q    <= 6'h00;
      cnt_q    <= 16'h0000;
      ack_q    <= 1'b0;
      rdata_q  <= 8'h00;
      pwr_q    <= '0;
      done_q   <= 1'b0;
    end else begin
      cr0_q    <= cr0_d;
      cr1_q    <= cr1_d;
      chsel_q  <= chsel_d;
      ckdiv_q  <= ckdiv_d;
      eoc_q    <= eoc_d;
      result_q <= result_d;
      armed_q  <= armed_d;
      div_q    <= div_d;
      cnt_q    <= cnt_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      pwr_q    <= pwr_d;
      done_q   <= done_d;
    end
  end
endmodule : sdc_device

// ---- src/sdc_host.sv ----
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module sdc_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sdc_link_if.host         link
);
  import sdc_pkg::*;

  sdc_hstate_type st_q;
  sdc_hstate_type st_d;
  logic [3:0]     step_q;
  logic [3:0]     step_d;
  logic [23:0]    cfg_q;
  logic [23:0]    cfg_d;
  logic [23:0]    res_q;
  logic [23:0]    res_d;
  logic           valid_q;
  logic           valid_d;
  logic           awr_q;
  logic           awr_d;
  logic [3:0]     aaddr_q;
  logic [3:0]     aaddr_d;
  logic [31:0]    rdat_q;
  logic [31:0]    rdat_d;
  logic [7:0]     lka_q;
  logic [7:0]     lka_d;
  logic [7:0]     lkw_q;
  logic [7:0]     lkw_d;
  logic           lkwr_q;
  logic           lkwr_d;
  logic           lkrd_q;
  logic           lkrd_d;
  logic           go_start;
  logic           go_read;
  logic           go_sleep;
  logic           go_off;
  logic [7:0]     cr0_base;
  logic [7:0]     cr1_clr;

  assign hrdata    = rdat_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign link.addr  = lka_q;
  assign link.wdata = lkw_q;
  assign link.wr    = lkwr_q;
  assign link.rd    = lkrd_q;

  always_comb begin
    cfg_d   = cfg_q;
    awr_d   = 1'b0;
    aaddr_d = aaddr_q;
    rdat_d  = rdat_q;
    if (hsel && htrans[1] && hready) begin
      aaddr_d = haddr[3:0];
      awr_d   = hwrite;
      if (!hwrite) begin
        unique case (haddr[3:0])
          H_CFG:    rdat_d = {8'h00, cfg_q};
          H_STATUS: rdat_d = {30'h0, valid_q, st_q != HS_IDLE};
          H_RESULT: rdat_d = {{8{res_q[23]}}, res_q};
          default:  rdat_d = 32'h0;
        endcase
      end
    end
    go_start = awr_q && aaddr_q == H_CTRL && hwdata[0];
    go_read  = awr_q && aaddr_q == H_CTRL && hwdata[1];
    go_sleep = awr_q && aaddr_q == H_CTRL && hwdata[2];
    go_off   = awr_q && aaddr_q == H_CTRL && hwdata[3];
    if (awr_q && aaddr_q == H_CFG) begin
      cfg_d = hwdata[23:0];
    end

    // Mode bits are owned by the sequence, not by software
    cr0_base = {3'b000, cfg_q[4:0]};
    cr1_clr  = {cfg_q[15:10], 2'b00};
    st_d     = st_q;
    step_d   = step_q;
    res_d    = res_q;
    valid_d  = valid_q;
    lka_d    = lka_q;
    lkw_d    = lkw_q;
    lkwr_d   = 1'b0;
    lkrd_d   = 1'b0;
    unique case (st_q)
      HS_IDLE: begin
        if (go_start) begin
          step_d = 4'h0;
          st_d   = HS_ISSUE;
        end else if (go_read) begin
          step_d  = ST_POLL;
          valid_d = 1'b0;
          st_d    = HS_ISSUE;
        end else if (go_off) begin
          step_d = 4'h7;
          st_d   = HS_ISSUE;
        end else if (go_sleep) begin
          step_d = 4'h6;
          st_d   = HS_ISSUE;
        end
      end
      HS_ISSUE: begin
        st_d   = HS_WAIT;
        lkwr_d = 1'b1;
        lkw_d  = 8'h00;
        unique case (step_q)
          4'h0: begin
            lka_d = A_CLKDIV;
            lkw_d = {3'b000, CLKDIV_CODE};
          end
          4'h1: begin
            lka_d = A_CR1;
            lkw_d = cr1_clr;
          end
          4'h2: begin
            lka_d = A_CHSEL;
            lkw_d = cfg_q[23:16];
          end
          4'h3, 4'h5: begin
            lka_d = A_CR0;
            lkw_d = cr0_base;
          end
          4'h4: begin
            lka_d = A_CR0;
            lkw_d = cr0_base | (8'h01 << CR0_RST);
          end
          4'h6: begin
            lka_d = A_CR0;
            lkw_d = cr0_base | (8'h01 << CR0_SLP);
          end
          4'h7: begin
            lka_d = A_CR0;
            lkw_d = cr0_base | (8'h01 << CR0_PD);
          end
          4'h8: begin
            lka_d  = A_CR1;
            lkwr_d = 1'b0;
            lkrd_d = 1'b1;
          end
          4'h9, 4'hA, 4'hB: begin
            lka_d  = 8'(A_RES_L + {4'h0, step_q} - 8'h09);
            lkwr_d = 1'b0;
            lkrd_d = 1'b1;
          end
          default: begin
            // final write clears the completion flag
            lka_d = A_CR1;
            lkw_d = cr1_clr;
          end
        endcase
      end
      HS_WAIT: begin
        if (link.ack) begin
          st_d   = HS_ISSUE;
          step_d = 4'(step_q + 4'h1);
          unique case (step_q)
            // repoll until the flag reads high
            ST_POLL: if (!link.rdata[CR1_EOC]) step_d = ST_POLL;
            4'h9: res_d[7:0]   = link.rdata;
            4'hA: res_d[15:8]  = link.rdata;
            4'hB: res_d[23:16] = link.rdata;
            ST_START_END: st_d = HS_IDLE;
            4'h6, 4'h7:   st_d = HS_IDLE;
            ST_READ_END: begin
              st_d    = HS_IDLE;
              valid_d = 1'b1;
            end
            default: ;
          endcase
        end
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= HS_IDLE;
      step_q  <= 4'h0;
      cfg_q   <= HCFG_RESET;
      res_q   <= 24'h000000;
      valid_q <= 1'b0;
      awr_q   <= 1'b0;
      aaddr_q <= 4'h0;
      rdat_q  <= 32'h0;
      lka_q   <= 8'h00;
      lkw_q   <= 8'h00;
      lkwr_q  <= 1'b0;
      lkrd_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      step_q  <= step_d;
      cfg_q   <= cfg_d;
      res_q   <= res_d;
      valid_q <= valid_d;
      awr_q   <= awr_d;
      aaddr_q <= aaddr_d;
      rdat_q  <= rdat_d;
      lka_q   <= lka_d;
      lkw_q   <= lkw_d;
      lkwr_q  <= lkwr_d;
      lkrd_q  <= lkrd_d;
    end
  end
endmodule : sdc_host

// ---- tb/sdc_asserts.sv ----
`timescale 1ns/1ps
module sdc_asserts (
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic [7:0]                addr,
  input wire logic [7:0]                wdata,
  input wire logic [7:0]                rdata,
  input wire logic                      wr,
  input wire logic                      rd,
  input wire logic                      ack,
  input wire logic [sdc_pkg::PWR_W-1:0] power_en,
  input wire logic                      conv_tick
);
  import sdc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_strobe;
    wr || rd;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  sequence s_rst_write;
    wr && addr == A_CR0 && !wdata[CR0_PD] && !wdata[CR0_SLP] && wdata[CR0_RST];
  endsequence
  AST_ACK_FOLLOWS: assert property (s_strobe |=> s_answer)
    else $error("link strobe not answered by a one-cycle ack");
  AST_ACK_CAUSE: assert property (ack |-> $past(wr || rd))
    else $error("ack without a strobe");
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  AST_PD_ALL_OFF: assert property (!power_en[PW_BG] |-> power_en[PW_FRST:PW_AMP] == '0)
    else $error("section on while bandgap off");
  AST_SLEEP_OFF: assert property (
    !power_en[PW_MOD] |-> !power_en[PW_TEMP] && !power_en[PW_VRN] && !power_en[PW_VRP])
    else $error("sensor or buffer on without modulator");
  AST_MOD_CORE: assert property (power_en[PW_MOD] |-> power_en[PW_BG] && power_en[PW_AMP])
    else $error("modulator on without bandgap and amplifier");
  AST_RST_WRITE: assert property (
    s_rst_write |-> ##[1:3] power_en[PW_FRST] && power_en[PW_MOD])
    else $error("filter not held in reset after reset write");
  AST_TICK_NORMAL: assert property (conv_tick |-> power_en[PW_MOD])
    else $error("conversion ended with modulator off");
  AST_TICK_PULSE: assert property (conv_tick |=> !conv_tick)
    else $error("conversion pulse longer than one cycle");
endmodule : sdc_asserts

// ---- tb/sdc_tb.sv ----
`timescale 1ns/1ps
module sdc_tb;
  import sdc_pkg::*;
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [RES_W-1:0]     sample_data;
  logic                 sample_over;
  logic [PWR_W-1:0]     power_en;
  logic                 conv_tick;
  logic [31:0]          q;
  logic [23:0]          va;
  integer               seed;
  integer               errors;
  integer               num_checks;
  integer               span;
  sdc_link_if link();
  sdc_host sdc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
  sdc_device sdc_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
    .sample_data(sample_data), .sample_over(sample_over), .power_en(power_en),
    .conv_tick(conv_tick));
  sdc_asserts sdc_asserts_inst (.hclk(hclk), .hresetn(hresetn), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .wr(link.wr), .rd(link.rd), .ack(link.ack),
    .power_en(power_en), .conv_tick(conv_tick));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb
  task automatic wait_ticks(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(posedge hclk);
      while (conv_tick !== 1'b1 && k < 5000) begin
        @(posedge hclk);
        k++;
      end
      if (k == 5000) chk("conv_tick", 32'h0, 32'h1);
    end
  endtask : wait_ticks
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      ahb(1'b0, 32'(H_STATUS), 32'h0);
      k++;
    end while (q[b] !== v && k < 3000);
    if (k == 3000) chk("status", q, 32'(v) << b);
  endtask : poll
  // Settle time lets the sequence clear the stale valid bit
  task automatic convert_read(input int n);
    wait_ticks(n);
    ahb(1'b1, 32'(H_CTRL), 32'h2);
    repeat (4) @(posedge hclk);
    poll(1, 1'b1);
    ahb(1'b0, 32'(H_RESULT), 32'h0);
  endtask : convert_read
  function automatic logic [PWR_W-1:0] exp_pwr(input logic [23:0] c);
    logic t;
    t = (c[18:16] == TEMP_SEL) || (c[21:19] == TEMP_SEL);
    return {c[4], c[3], 1'b0, 1'b1, c[13], c[14], t, 3'b111};
  endfunction : exp_pwr
  function automatic logic [31:0] exp_res(input logic [23:0] v, input logic ov);
    logic [23:0] r;
    r = ov ? RES_OVER : v;
    return {{8{r[23]}}, r};
  endfunction : exp_res
  initial begin
    repeat (90000) @(posedge hclk);
    errors++;
    test_done();
  end
  initial begin
    seed = 93;
    errors = 0;
    num_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    sample_data = 24'h0;
    sample_over = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("power_en", 32'(power_en), 32'h0);
    ahb(1'b0, 32'(H_STATUS), 32'h0);
    chk("status", q, 32'h0);
    ahb(1'b0, 32'(H_CFG), 32'h0);
    chk("cfg", q, 32'(HCFG_RESET));
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    ahb(1'b1, 32'(H_CFG), 32'h076818);
    ahb(1'b0, 32'(H_CFG), 32'h0);
    chk("cfg", q, 32'h076818);
    ahb(1'b1, 32'(H_CTRL), 32'h1);
    repeat (4) @(posedge hclk);
    poll(0, 1'b0);
    chk("power_en", 32'(power_en), 32'(exp_pwr(24'h076818)));
    $display("test start done");
    // Conversion spacing set by divider and length
    wait_ticks(1);
    span = 0;
    do begin
      @(posedge hclk);
      span++;
    end while (conv_tick !== 1'b1 && span < 5000);
    chk("span", span, 32'(BASE_SHORT << OSR_SHIFT) * 32'(2 * CLKDIV_CODE + 2));
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: va = 24'h7FFFFF;
        1: va = 24'h800000;
        2: va = 24'h000001;
        3: va = 24'h000000;
        default: va = 24'($random(seed));
      endcase
      sample_data <= va;
      sample_over <= (i == 2);
      convert_read(2);
      chk("result", q, exp_res(va, i == 2));
    end
    $display("test results done");
    va = 24'($random(seed));
    sample_over <= 1'b0;
    sample_data <= va;
    ahb(1'b1, 32'(H_CFG), 32'h078818);
    convert_read(2);
    chk("result", q, exp_res(va, 1'b0));
    repeat (2) @(posedge hclk);
    chk("power_en", 32'(power_en), 32'(exp_pwr(24'h078818)));
    sample_data <= ~va;
    convert_read(2);
    chk("result", q, exp_res(va, 1'b0));
    ahb(1'b1, 32'(H_CFG), 32'h076818);
    convert_read(1);
    chk("result", q, exp_res(va, 1'b0));
    convert_read(2);
    chk("result", q, exp_res(~va, 1'b0));
    $display("test hold done");
    ahb(1'b1, 32'(H_CTRL), 32'h4);
    repeat (4) @(posedge hclk);
    poll(0, 1'b0);
    chk("power_en", 32'(power_en), 32'h343);
    ahb(1'b1, 32'(H_CTRL), 32'h8);
    repeat (4) @(posedge hclk);
    poll(0, 1'b0);
    chk("power_en", 32'(power_en), 32'h300);
    // Power-down drops arming; a new reset pulse restarts
    va = 24'($random(seed));
    sample_data <= va;
    ahb(1'b1, 32'(H_CTRL), 32'h1);
    repeat (4) @(posedge hclk);
    poll(0, 1'b0);
    convert_read(2);
    chk("result", q, exp_res(va, 1'b0));
    $display("test modes done");
    test_done();
  end
endmodule : sdc_tb
